// ==== rtl/status_fault_event_irq.sv ====
// Status, power-down cause log, event latching and host interrupt generation
`default_nettype none

// Overview of operation
// - Status-low bits 1:0 show general inputs, or ADC high-threshold flag when ADC owns pin.
// - Current-limit bits 7:3 follow regulator over-current flags live; bits 2:0 read zero.
// - Fault log bit 7 on identification wait timeout, bit 6 on external shutdown.
// - Fault log bit 5 on long key press reset, bit 4 on over-temperature.
// - Under-voltage sets bit 3 before or within 16 s of active, else bit 2.
// - Fault log bit 1 on start from unpowered or delivery, bit 0 on watchdog.
// - Host clears fault and event bits by writing ones back; zeros leave bits.
// - Any change of a monitored status signal sets its event bit.
// - Interrupt output low while any unmasked event bit is set.
// - Interrupt held inactive during power-up; pending unmasked events assert it once power-up ends.
// - Event registers readable by auto-increment or repeated-address multi-byte reads.
// - Events arriving during a clearing write are deferred one cycle, never lost.
// - Group one bit 5 ORs group two, bit 6 groups two and three, bit 7 groups two to four.
// - Group one bit 4 on sequencer done, bit 3 on ADC result ready.
// - Group one bit 2 latches on each clock tick indication.
// - Group one bit 1 on clock alarm, bit 0 on power key event.
// - Group two bit 7 latches when supply falls below upper warning threshold.
// - Group two bit 5 latches when all dynamic voltage ramps finish.
// - Group two bit 4 on regulator out of range or new measurement, per select.
// - Group two bit 3 only once over-current has persisted for 10 ms.
// - Group two bit 2 latches on low comparator output activity.
// - Interrupt released only after every register with unmasked set events is written back.
// - Each event bit has a read-write mask bit that blocks its interrupt.
module status_fault_event_irq
  import status_event_pkg::*;
#(
  parameter int unsigned OVERCURRENT_LIMIT = OVERCURRENT_CYCLES,
  parameter int unsigned UV_WINDOW = UV_START_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register access from the serial control interface
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Monitored levels
  input wire logic [15:0] general_input_pin,
  input wire logic [1:0] analog_input_select,
  input wire logic [1:0] analog_input_high,
  input wire logic [4:0] regulator_overcurrent,
  input wire logic power_key_n,
  input wire logic low_comparator_level,
  input wire logic active_mode,
  input wire logic powerup_active,
  input wire logic monitor_select,
  // Event pulses
  input wire logic sequencer_done_event,
  input wire logic adc_result_ready,
  input wire logic rtc_tick,
  input wire logic rtc_alarm,
  input wire logic supply_warn_fall,
  input wire logic supply_monitor_event,
  input wire logic ramp_done_event,
  input wire logic regulator_out_of_range,
  input wire logic regulator_new_measurement,
  input wire logic overtemp_event,
  input wire logic wake_rise,
  // Power-down cause pulses
  input wire logic cause_id_wait,
  input wire logic external_shutdown_cause,
  input wire logic cause_key_reset,
  input wire logic junction_overtemp_cause,
  input wire logic cause_undervoltage,
  input wire logic cause_delivery_start,
  input wire logic watchdog_violation_flag,
  // Host interrupt
  output logic host_interrupt_out_n
);

  localparam logic [OC_CNT_W-1:0] OC_LAST = OC_CNT_W'(OVERCURRENT_LIMIT - 1);
  localparam logic [UV_CNT_W-1:0] UV_END = UV_CNT_W'(UV_WINDOW);

  state_s st;
  state_s next_st;
  logic [7:0] status_low;
  logic [15:0] levels;
  logic any_limit;
  logic oc_fire;
  logic in_window;
  logic [3:0][7:0] new_ev;
  logic [7:0] fault_set;
  logic [2:0] summary;

  function automatic logic [7:0] group_addr(input logic [7:0] base, input int k);
    group_addr = 8'(base + 8'(k));
  endfunction : group_addr

  ////////////////////////////////////////////////////////////////////////////////
  // Live status and event sources

  always_comb begin
    status_low[7:2] = general_input_pin[7:2];
    for (int i = 0; i < 2; i++) begin
      status_low[i] = analog_input_select[i] ? analog_input_high[i]
                                             : general_input_pin[i];
    end
    levels = {general_input_pin[15:8], status_low};
    any_limit = |regulator_overcurrent;
    oc_fire = any_limit && (st.oc_cnt == OC_LAST);
    in_window = !active_mode || (st.uv_cnt != UV_END);
    summary[0] = |st.ev[1];
    summary[1] = summary[0] | (|st.ev[2]);
    summary[2] = summary[1] | (|st.ev[3]);
    new_ev = '0;
    new_ev[0][EA_SEQ] = sequencer_done_event;
    new_ev[0][EA_ADC] = adc_result_ready;
    new_ev[0][EA_TICK] = rtc_tick;
    new_ev[0][EA_ALARM] = rtc_alarm;
    new_ev[0][EA_KEY] = st.primed && (power_key_n != st.key_prev);
    new_ev[1][EB_VDD_WARN] = supply_warn_fall;
    new_ev[1][EB_VDD_MON] = supply_monitor_event;
    new_ev[1][EB_RAMP] = ramp_done_event;
    new_ev[1][EB_REG_MON] = monitor_select ? regulator_new_measurement
                                           : regulator_out_of_range;
    new_ev[1][EB_OVERCURRENT] = oc_fire;
    new_ev[1][EB_COMP] = st.primed && (low_comparator_level != st.comp_prev);
    new_ev[1][EB_TEMP] = overtemp_event;
    new_ev[1][EB_WAKE] = wake_rise;
    // First cycle after reset only samples, so idle-high pins raise nothing
    if (st.primed) begin
      new_ev[2] = levels[7:0] ^ st.level_prev[7:0];
      new_ev[3] = levels[15:8] ^ st.level_prev[15:8];
    end
    fault_set = '0;
    fault_set[FL_ID_WAIT] = cause_id_wait;
    fault_set[FL_SHUTDOWN] = external_shutdown_cause;
    fault_set[FL_KEY_RESET] = cause_key_reset;
    fault_set[FL_OVERTEMP] = junction_overtemp_cause;
    fault_set[FL_UV_START] = cause_undervoltage && in_window;
    fault_set[FL_UV_OTHER] = cause_undervoltage && !in_window;
    fault_set[FL_POR] = cause_delivery_start;
    fault_set[FL_WATCHDOG] = watchdog_violation_flag;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_st = st;
    for (int k = 0; k < 4; k++) begin
      if (reg_wr && reg_addr == group_addr(ADDR_EVENT_ONE, k)) begin
        // Fresh events wait one cycle so the write cannot swallow them
        next_st.ev[k] = (st.ev[k] & ~reg_wdata) | st.defer[k];
        next_st.defer[k] = new_ev[k];
      end else begin
        next_st.ev[k] = st.ev[k] | new_ev[k] | st.defer[k];
        next_st.defer[k] = 8'h00;
      end
      if (reg_wr && reg_addr == group_addr(ADDR_MASK_ONE, k)) begin
        next_st.mask[k] = reg_wdata;
      end
    end
    next_st.ev[0][EA_ALL:EA_TWO] = 3'h0;
    next_st.fault_log = st.fault_log | fault_set;
    if (reg_wr && reg_addr == ADDR_FAULT_LOG) begin
      next_st.fault_log = (st.fault_log & ~reg_wdata) | fault_set;
    end
    next_st.level_prev = levels;
    next_st.key_prev = power_key_n;
    next_st.comp_prev = low_comparator_level;
    next_st.primed = 1'b1;
    if (!any_limit) begin
      next_st.oc_cnt = '0;
    end else if (st.oc_cnt != OC_LAST + 1'b1) begin
      next_st.oc_cnt = st.oc_cnt + 1'b1;
    end
    if (!active_mode) begin
      next_st.uv_cnt = '0;
    end else if (st.uv_cnt != UV_END) begin
      next_st.uv_cnt = st.uv_cnt + 1'b1;
    end
    // Reads have no side effect, so bursts and repeats see the same data
    next_st.rvalid = reg_rd;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_STATUS_LOW: next_st.rdata = status_low;
        ADDR_STATUS_HIGH: next_st.rdata = general_input_pin[15:8];
        ADDR_CUR_LIMIT: next_st.rdata = {regulator_overcurrent, 3'h0};
        ADDR_FAULT_LOG: next_st.rdata = st.fault_log;
        ADDR_EVENT_ONE: next_st.rdata = {summary[2], summary[1], summary[0],
                                         st.ev[0][EA_SEQ:EA_KEY]};
        ADDR_EVENT_TWO: next_st.rdata = st.ev[1];
        ADDR_EVENT_THREE: next_st.rdata = st.ev[2];
        ADDR_EVENT_FOUR: next_st.rdata = st.ev[3];
        group_addr(ADDR_MASK_ONE, 0): next_st.rdata = st.mask[0];
        group_addr(ADDR_MASK_ONE, 1): next_st.rdata = st.mask[1];
        group_addr(ADDR_MASK_ONE, 2): next_st.rdata = st.mask[2];
        group_addr(ADDR_MASK_ONE, 3): next_st.rdata = st.mask[3];
        default: next_st.rdata = 8'h00;
      endcase
    end
    // Outside power-up, stays low until every group with pending unmasked bits is written back
    next_st.irq_n = powerup_active || !(|(st.ev & ~st.mask));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign reg_rvalid = st.rvalid;
  assign host_interrupt_out_n = st.irq_n;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_clear_with_warn;
    reg_wr && reg_addr == ADDR_EVENT_TWO && reg_wdata[EB_VDD_WARN] && supply_warn_fall;
  endsequence

  sequence s_deferred_then_latched;
    st.defer[1][EB_VDD_WARN] ##1 st.ev[1][EB_VDD_WARN];
  endsequence

  AST_IRQ_LEVEL: assert property (
    ##1 host_interrupt_out_n == ($past(powerup_active) || !(|($past(st.ev) & ~$past(st.mask)))))
    else $error("interrupt output does not follow unmasked events");

  AST_IRQ_POWERUP: assert property (
    powerup_active [*2] |-> host_interrupt_out_n)
    else $error("interrupt asserted during power-up");

  AST_IRQ_MASKED: assert property (
    (st.mask == '1) [*2] |-> host_interrupt_out_n)
    else $error("fully masked events still drive interrupt");

  AST_FAULT_SET: assert property (
    cause_id_wait |=> st.fault_log[FL_ID_WAIT])
    else $error("fault log misses identification timeout");

  AST_FAULT_CLEAR: assert property (
    reg_wr && reg_addr == ADDR_FAULT_LOG && fault_set == 8'h00
    |=> (st.fault_log & $past(reg_wdata)) == 8'h00 && (st.fault_log | $past(reg_wdata))
        == ($past(st.fault_log) | $past(reg_wdata)))
    else $error("fault log write-back clear wrong");

  AST_DEFER: assert property (
    s_clear_with_warn |=> s_deferred_then_latched)
    else $error("event during clearing write was lost");

  AST_SUMMARY: assert property (
    reg_rd && reg_addr == ADDR_EVENT_ONE
    |=> reg_rvalid && reg_rdata[EA_TWO] == $past(|st.ev[1])
        && reg_rdata[EA_ALL] == $past((|st.ev[1]) | (|st.ev[2]) | (|st.ev[3])))
    else $error("summary bits wrong");

  AST_LIMIT_READ: assert property (
    reg_rd && reg_addr == ADDR_CUR_LIMIT |=> reg_rdata == {$past(regulator_overcurrent), 3'h0})
    else $error("current limit status read wrong");

  AST_OC_DELAY: assert property (
    $rose(st.ev[1][EB_OVERCURRENT]) && !$past(st.defer[1][EB_OVERCURRENT])
    |-> $past(any_limit) && $past(st.oc_cnt) == OC_LAST)
    else $error("over-current event without persistence");

  AST_GPI_EVENT: assert property (
    st.primed && !reg_wr && general_input_pin[7] != st.level_prev[7] |=> st.ev[2][7])
    else $error("level change did not latch event");

  AST_STATUS_LOW: assert property (
    reg_rd && reg_addr == ADDR_STATUS_LOW && analog_input_select[0]
    |=> reg_rdata[0] == $past(analog_input_high[0]))
    else $error("status low ignores ADC override");

  AST_CAUSE_SHUTDOWN: assert property (
    external_shutdown_cause |=> st.fault_log[FL_SHUTDOWN])
    else $error("fault log misses external shutdown");

  AST_CAUSE_KEY: assert property (
    cause_key_reset |=> st.fault_log[FL_KEY_RESET])
    else $error("fault log misses long key press");

  AST_CAUSE_TEMP: assert property (
    junction_overtemp_cause |=> st.fault_log[FL_OVERTEMP])
    else $error("fault log misses over-temperature");

  AST_UV_EARLY: assert property (
    cause_undervoltage && !active_mode |=> st.fault_log[FL_UV_START])
    else $error("early under-voltage not logged as start fault");

  AST_UV_LATE: assert property (
    cause_undervoltage && active_mode && st.uv_cnt == UV_END |=> st.fault_log[FL_UV_OTHER])
    else $error("late under-voltage not logged as plain fault");

  AST_CAUSE_POR: assert property (
    cause_delivery_start |=> st.fault_log[FL_POR])
    else $error("fault log misses cold start");

  AST_CAUSE_WDOG: assert property (
    watchdog_violation_flag |=> st.fault_log[FL_WATCHDOG])
    else $error("fault log misses watchdog violation");

  // A pulse lands in the register, or in the deferral slot during a clearing write
  AST_SEQ_EVENT: assert property (
    sequencer_done_event |=> st.ev[0][EA_SEQ] || st.defer[0][EA_SEQ])
    else $error("sequencer done event lost");

  AST_TICK_EVENT: assert property (
    rtc_tick |=> st.ev[0][EA_TICK] || st.defer[0][EA_TICK])
    else $error("clock tick event lost");

  AST_KEY_EVENT: assert property (
    st.primed && $changed(power_key_n) |=> st.ev[0][EA_KEY] || st.defer[0][EA_KEY])
    else $error("power key event lost");

  AST_WARN_EVENT: assert property (
    supply_warn_fall |=> st.ev[1][EB_VDD_WARN] || st.defer[1][EB_VDD_WARN])
    else $error("supply warning event lost");

  AST_RAMP_EVENT: assert property (
    ramp_done_event |=> st.ev[1][EB_RAMP] || st.defer[1][EB_RAMP])
    else $error("ramp done event lost");

  AST_REG_MON_EVENT: assert property (
    (monitor_select ? regulator_new_measurement : regulator_out_of_range)
    |=> st.ev[1][EB_REG_MON] || st.defer[1][EB_REG_MON])
    else $error("selected regulator monitor event lost");

  AST_COMP_EVENT: assert property (
    st.primed && $changed(low_comparator_level)
    |=> st.ev[1][EB_COMP] || st.defer[1][EB_COMP])
    else $error("comparator event lost");

  AST_READ_VALID: assert property (
    reg_rd |=> reg_rvalid)
    else $error("read not answered in the next cycle");

endmodule : status_fault_event_irq
`default_nettype wire

// ==== rtl/status_event_pkg.sv ====
// Constants, register map and state type for the status, fault-log and event block
`default_nettype none
package status_event_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_STATUS_LOW = 8'h02;
  localparam logic [7:0] ADDR_STATUS_HIGH = 8'h03;
  localparam logic [7:0] ADDR_CUR_LIMIT = 8'h04;
  localparam logic [7:0] ADDR_FAULT_LOG = 8'h05;
  localparam logic [7:0] ADDR_EVENT_ONE = 8'h06;
  localparam logic [7:0] ADDR_EVENT_TWO = 8'h07;
  localparam logic [7:0] ADDR_EVENT_THREE = 8'h08;
  localparam logic [7:0] ADDR_EVENT_FOUR = 8'h09;
  localparam logic [7:0] ADDR_MASK_ONE = 8'h0a;
  // Fault log fields
  localparam int FL_ID_WAIT = 7;
  localparam int FL_SHUTDOWN = 6;
  localparam int FL_KEY_RESET = 5;
  localparam int FL_OVERTEMP = 4;
  localparam int FL_UV_START = 3;
  localparam int FL_UV_OTHER = 2;
  localparam int FL_POR = 1;
  localparam int FL_WATCHDOG = 0;
  // Event group one fields
  localparam int EA_ALL = 7;
  localparam int EA_TWO_THREE = 6;
  localparam int EA_TWO = 5;
  localparam int EA_SEQ = 4;
  localparam int EA_ADC = 3;
  localparam int EA_TICK = 2;
  localparam int EA_ALARM = 1;
  localparam int EA_KEY = 0;
  // Event group two fields
  localparam int EB_VDD_WARN = 7;
  localparam int EB_VDD_MON = 6;
  localparam int EB_RAMP = 5;
  localparam int EB_REG_MON = 4;
  localparam int EB_OVERCURRENT = 3;
  localparam int EB_COMP = 2;
  localparam int EB_TEMP = 1;
  localparam int EB_WAKE = 0;
  // Current-limit flags occupy bits 7 down to this one
  localparam int CL_LSB = 3;
  // Reset values
  localparam logic [7:0] FAULT_LOG_RESET = 8'h02;
  localparam logic [7:0] MASK_RESET = 8'h00;
  // Timing
  localparam longint CLK_PERIOD_NS = 100;
  localparam longint OVERCURRENT_TIME_MS = 10;
  localparam longint UV_START_WINDOW_S = 16;
  localparam int unsigned OVERCURRENT_CYCLES =
    int'(OVERCURRENT_TIME_MS * 64'd1000000 / CLK_PERIOD_NS);
  localparam int unsigned UV_START_CYCLES =
    int'(UV_START_WINDOW_S * 64'd1000000000 / CLK_PERIOD_NS);
  localparam int OC_CNT_W = 17;
  localparam int UV_CNT_W = 28;

  typedef struct packed {
    logic [3:0][7:0] ev;
    logic [3:0][7:0] defer;
    logic [3:0][7:0] mask;
    logic [7:0] fault_log;
    logic [15:0] level_prev;
    logic key_prev;
    logic comp_prev;
    logic primed;
    logic [OC_CNT_W-1:0] oc_cnt;
    logic [UV_CNT_W-1:0] uv_cnt;
    logic [7:0] rdata;
    logic rvalid;
    logic irq_n;
  } state_s;

  localparam state_s STATE_RESET = '{
    ev: '0, defer: '0, mask: {4{MASK_RESET}}, fault_log: FAULT_LOG_RESET,
    level_prev: '0, key_prev: 1'b1, comp_prev: 1'b0, primed: 1'b0,
    oc_cnt: '0, uv_cnt: '0, rdata: 8'h00, rvalid: 1'b0, irq_n: 1'b1};
endpackage : status_event_pkg
`default_nettype wire

// ==== test/host_model.sv ====
// Host-side model: register reads, writes and event write-back
`default_nettype none
module host_model (
  // Clock
  input wire logic clk,
  // Register bus towards the device
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  ////////////////////////////////////////////////////////////
  // Idle bus shows inverted last values, so a stale copy never passes
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~v;
  endtask : wr

  // Write back exactly what was read
  task automatic clear_group(input logic [7:0] a);
    logic [7:0] v;
    rd(a, v);
    wr(a, v);
  endtask : clear_group

  task automatic clear_all();
    for (int a = 6; a < 10; a++) begin
      clear_group(8'(a));
    end
  endtask : clear_all
endmodule : host_model
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the status, fault-log and event block
`default_nettype none
module tb_top
  import status_event_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_wr;
  logic reg_rd;
  logic reg_rvalid;
  logic irq_n;
  logic [15:0] gpin = 16'h0000;
  logic [1:0] asel = 2'b00;
  logic [1:0] ahigh = 2'b00;
  logic [4:0] oc = 5'h00;
  logic key_n = 1'b1;
  logic comp = 1'b0;
  logic act = 1'b0;
  logic pwrup = 1'b0;
  logic msel = 1'b0;
  // Event pulses; slots 11 and 12 stand for key and comparator toggles
  logic [10:0] pe = 11'h000;
  // Power-down causes; bit 6 is under-voltage
  logic [6:0] fc = 7'h00;
  int bad_count = 0;
  int total_checks = 0;
  logic [7:0] d;
  int ebit[13] = '{4, 3, 2, 1, 7, 6, 5, 4, 1, 0, 4, 0, 2};
  int fbit[6] = '{7, 6, 5, 4, 1, 0};

  status_fault_event_irq #(.OVERCURRENT_LIMIT(8), .UV_WINDOW(20)) u_status_fault_event_irq (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .general_input_pin(gpin), .analog_input_select(asel), .analog_input_high(ahigh),
    .regulator_overcurrent(oc), .power_key_n(key_n), .low_comparator_level(comp),
    .active_mode(act), .powerup_active(pwrup), .monitor_select(msel),
    .sequencer_done_event(pe[0]), .adc_result_ready(pe[1]), .rtc_tick(pe[2]),
    .rtc_alarm(pe[3]), .supply_warn_fall(pe[4]), .supply_monitor_event(pe[5]),
    .ramp_done_event(pe[6]), .regulator_out_of_range(pe[7]), .overtemp_event(pe[8]),
    .wake_rise(pe[9]), .regulator_new_measurement(pe[10]), .cause_id_wait(fc[0]),
    .external_shutdown_cause(fc[1]), .cause_key_reset(fc[2]), .junction_overtemp_cause(fc[3]),
    .cause_delivery_start(fc[4]), .watchdog_violation_flag(fc[5]), .cause_undervoltage(fc[6]),
    .host_interrupt_out_n(irq_n));

  host_model u_host_model (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  always #50 clk = ~clk;

  ////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    u_host_model.rd(a, d);
    chk($sformatf("register %h", a), e, d);
  endtask : rdchk

  task automatic irqchk(input logic e);
    chk("interrupt line", {7'h00, e}, {7'h00, irq_n});
  endtask : irqchk

  task automatic t_reset();
    irqchk(1'b1);
    rdchk(ADDR_FAULT_LOG, 8'h02);
    u_host_model.clear_group(ADDR_FAULT_LOG);
    rdchk(ADDR_FAULT_LOG, 8'h00);
    rdchk(8'h40, 8'h00);
  endtask : t_reset

  task automatic t_status();
    gpin = 16'ha5c3;
    rdchk(ADDR_STATUS_LOW, 8'hc3);
    rdchk(ADDR_STATUS_HIGH, 8'ha5);
    asel = 2'b11;
    ahigh = 2'b01;
    rdchk(ADDR_STATUS_LOW, 8'hc1);
    u_host_model.wr(ADDR_STATUS_HIGH, 8'hff);
    rdchk(ADDR_STATUS_HIGH, 8'ha5);
    oc = 5'b10110;
    rdchk(ADDR_CUR_LIMIT, 8'hb0);
    oc = 5'h00;
    u_host_model.clear_all();
    step(2);
    irqchk(1'b1);
  endtask : t_status

  task automatic t_fault();
    for (int i = 0; i < 6; i++) begin
      fc[i] = 1'b1;
      step(1);
      fc = 7'h00;
      rdchk(ADDR_FAULT_LOG, 8'h01 << fbit[i]);
      u_host_model.clear_group(ADDR_FAULT_LOG);
    end
    fc = 7'h03;
    step(1);
    fc = 7'h00;
    u_host_model.wr(ADDR_FAULT_LOG, 8'h80);
    rdchk(ADDR_FAULT_LOG, 8'h40);
    u_host_model.clear_group(ADDR_FAULT_LOG);
    // Window: inactive, just after active, long after active
    for (int k = 0; k < 3; k++) begin
      act = (k > 0);
      step(k == 2 ? 30 : 3);
      fc[6] = 1'b1;
      step(1);
      fc = 7'h00;
      rdchk(ADDR_FAULT_LOG, k == 2 ? 8'h04 : 8'h08);
      u_host_model.clear_group(ADDR_FAULT_LOG);
    end
  endtask : t_fault

  task automatic t_events();
    logic [7:0] grp_addr;
    pe[10] = 1'b1;
    step(1);
    pe = 11'h000;
    rdchk(ADDR_EVENT_TWO, 8'h00);
    for (int i = 0; i < 13; i++) begin
      msel = (i == 10);
      if (i < 11) begin
        pe[i] = 1'b1;
      end else if (i == 11) begin
        key_n = ~key_n;
      end else begin
        comp = ~comp;
      end
      step(1);
      pe = 11'h000;
      step(1);
      irqchk(1'b0);
      // Separate from d, which the read overwrites with register data
      grp_addr = (i < 4 || i == 11) ? ADDR_EVENT_ONE : ADDR_EVENT_TWO;
      rdchk(grp_addr, 8'h01 << ebit[i]);
      u_host_model.clear_group(grp_addr);
      step(2);
      irqchk(1'b1);
    end
  endtask : t_events

  task automatic t_summary();
    gpin[3] = ~gpin[3];
    step(2);
    rdchk(ADDR_EVENT_ONE, 8'hc0);
    pe[8] = 1'b1;
    step(1);
    pe = 11'h000;
    rdchk(ADDR_EVENT_ONE, 8'he0);
    u_host_model.clear_group(ADDR_EVENT_THREE);
    rdchk(ADDR_EVENT_ONE, 8'he0);
    irqchk(1'b0);
    u_host_model.clear_group(ADDR_EVENT_TWO);
    gpin[12] = ~gpin[12];
    step(2);
    rdchk(ADDR_EVENT_ONE, 8'h80);
    u_host_model.clear_group(ADDR_EVENT_FOUR);
    step(2);
    irqchk(1'b1);
  endtask : t_summary

  task automatic t_mask_defer();
    u_host_model.wr(ADDR_MASK_ONE, 8'h02);
    rdchk(ADDR_MASK_ONE, 8'h02);
    pe[3] = 1'b1;
    step(1);
    pe = 11'h000;
    step(2);
    irqchk(1'b1);
    rdchk(ADDR_EVENT_ONE, 8'h02);
    u_host_model.wr(ADDR_MASK_ONE, 8'h00);
    // Tick lands on the very edge that takes the clearing write
    fork
      u_host_model.wr(ADDR_EVENT_ONE, 8'h02);
      begin
        step(1);
        pe[2] = 1'b1;
        step(1);
        pe[2] = 1'b0;
      end
    join
    step(2);
    rdchk(ADDR_EVENT_ONE, 8'h04);
    u_host_model.clear_group(ADDR_EVENT_ONE);
    // Every mask set: a pending event must not reach the line
    for (int a = 10; a < 14; a++) begin
      u_host_model.wr(8'(a), 8'hff);
    end
    pe[4] = 1'b1;
    step(1);
    pe = 11'h000;
    step(2);
    irqchk(1'b1);
    for (int a = 10; a < 14; a++) begin
      u_host_model.wr(8'(a), 8'h00);
    end
    step(1);
    irqchk(1'b0);
    // Warning repeats on the edge of its own clearing write
    fork
      u_host_model.wr(ADDR_EVENT_TWO, 8'h80);
      begin
        step(1);
        pe[4] = 1'b1;
        step(1);
        pe[4] = 1'b0;
      end
    join
    step(2);
    rdchk(ADDR_EVENT_TWO, 8'h80);
    u_host_model.clear_group(ADDR_EVENT_TWO);
  endtask : t_mask_defer

  task automatic t_oc_powerup();
    oc = 5'b00001;
    step(6);
    oc = 5'h00;
    step(2);
    rdchk(ADDR_EVENT_TWO, 8'h00);
    oc = 5'b10000;
    step(12);
    oc = 5'h00;
    step(2);
    rdchk(ADDR_EVENT_TWO, 8'h08);
    u_host_model.clear_group(ADDR_EVENT_TWO);
    pwrup = 1'b1;
    pe[2] = 1'b1;
    step(1);
    pe = 11'h000;
    step(2);
    irqchk(1'b1);
    pwrup = 1'b0;
    step(2);
    irqchk(1'b0);
    u_host_model.clear_group(ADDR_EVENT_ONE);
    step(2);
    irqchk(1'b1);
  endtask : t_oc_powerup

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  initial begin
    step(2);
    rst_n = 1'b1;
    t_reset();
    t_status();
    t_fault();
    t_events();
    t_summary();
    t_mask_defer();
    t_oc_powerup();
    close_out();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #1000000;
    bad_count++;
    close_out();
  end
endmodule : tb_top
`default_nettype wire
